// file: inc/pmm_params.svh
// Constants for the power-mode manager: mode codes, divider codes, timing
// Assumes inclusion by bare name from design files; holds definitions only
`ifndef PMM_PARAMS_SVH
`define PMM_PARAMS_SVH

// Transceiver mode command codes (3 bits)
`define RMODE_SLEEP 3'h0
`define RMODE_IDLE 3'h1
`define RMODE_STANDBY 3'h2
`define RMODE_SYNTH 3'h3
`define RMODE_TX 3'h4
`define RMODE_RX 3'h5

// Clock output divider select codes: divide by 2**code, code 0..5
`define CLKDIV_MAX_CODE 3'h5

// Reset-recovery hold after waking from the deepest stop state, in ns
`define RECOVERY_NS 2000
`define CLK_PERIOD_NS 40
`define RECOVERY_CYCLES ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Peripheral module count for clock gating
`define NUM_PERIPH 8

`endif

// file: inc/pmm_pkg.sv
// Types shared by the power-mode manager files
// Assumes nothing outside itself
package pmm_pkg;
   // Transceiver operating mode
   typedef enum logic [2:0] {
      RM_SLEEP = 3'h0,
      RM_IDLE = 3'h1,
      RM_STANDBY = 3'h2,
      RM_SYNTH = 3'h3,
      RM_TX = 3'h4,
      RM_RX = 3'h5
   } radio_mode_t;

   // Microcontroller power state
   typedef enum logic [2:0] {
      MS_RUN = 3'h0,
      MS_WAIT = 3'h1,
      MS_RET_STOP = 3'h2,
      MS_DEEP_STOP = 3'h3,
      MS_RECOVER = 3'h4
   } mcu_state_t;
endpackage

// file: verilog/clk_divider.sv
// Programmable power-of-two divider for the divided clock output
// Assumes an enable tick on every reference edge, two per reference period,
// so code 0 runs at the reference rate and code 5 at one thirty-second of it
`timescale 1ns/1ns
`include "pmm_params.svh"
module clk_divider #(
   parameter int CNT_W = 6
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic run_in,
   input wire logic [2:0] div_sel_in,
   output logic clk_div_out
);
   logic [CNT_W-1:0] cnt_ff; // Free-running count of reference edges
   logic clk_ff; // Registered divided clock
   logic [2:0] sel; // Clamped selector

   // Codes above the largest divider are clamped to it
   always_comb begin
      sel = (div_sel_in > `CLKDIV_MAX_CODE) ? `CLKDIV_MAX_CODE : div_sel_in;
   end

   // Counter clears while the oscillator is off, and the output is held low
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cnt_ff <= '0;
      end else if (ce_in) begin
         if (run_in) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
         end else begin
            cnt_ff <= '0;
         end
      end
   end

   // Code n taps counter bit n, so each code up to 5 halves the rate of the one below;
   // codes 6 and 7 are clamped to tap bit 5 like code 5; needs at least six counter bits
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         clk_ff <= 1'b0;
      end else if (ce_in) begin
         if (!run_in) begin
            clk_ff <= 1'b0;
         end else begin
            clk_ff <= cnt_ff[sel];
         end
      end
   end

   assign clk_div_out = clk_ff;
endmodule

// file: verilog/sip_power_mode_manager.sv
// Power-mode manager for a two-die node: radio mode and MCU power states
// Assumes mode commands come from the control-port decoder on mclk_in;
// wake inputs from pins are asynchronous and are synchronised here
//
// Contract
// RULE1 - Sleep turns every regulator, oscillator, RF off
// RULE2 - Idle keeps main regulator and RC oscillator
// RULE3 - Standby keeps main regulator and crystal oscillator
// RULE4 - Synth-ready mode keeps the synthesizer running
// RULE5 - Transmitter only in TX, receiver only RX
// RULE6 - Radio mode changes only on command
// RULE7 - Host selects radio mode over control port
// RULE8 - Deepest stop keeps RAM, pins; oscillator off
// RULE9 - Deepest stop wake runs full reset recovery
// RULE10 - Retentive stop keeps RAM, registers, pins; oscillator configurable
// RULE11 - Retentive stop wake resumes via interrupt request
// RULE12 - Wait is shallower than either stop
// RULE13 - Wake from keyboard, UART and RTC
// RULE14 - Peripheral clock gating per module
// RULE15 - Clock output reference divided 1..32
// RULE16 - Host drives radio hardware reset from GPIO
// RULE17 - Exactly one radio mode, one-hot encoding
`timescale 1ns/1ns
`include "pmm_params.svh"
module sip_power_mode_manager #(
   parameter int NUM_PERIPH = `NUM_PERIPH,
   parameter int RECOVERY_CYCLES = `RECOVERY_CYCLES
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic radio_rst_in,
   input wire logic mode_wr_in,
   input wire logic [2:0] mode_in,
   input wire logic [2:0] clk_div_sel_in,
   input wire logic ref_tick_in,
   input wire logic wait_exec_in,
   input wire logic ret_stop_req_in,
   input wire logic deep_stop_req_in,
   input wire logic ret_stop_osc_en_in,
   input wire logic keyboard_wake_interrupt_in,
   input wire logic uart_rx_in,
   input wire logic rtc_wake_in,
   input wire logic irq_in,
   input wire logic [NUM_PERIPH-1:0] periph_clk_en_in,
   output logic [5:0] mode_onehot_out,
   output logic [2:0] mode_out,
   output logic main_reg_en_out,
   output logic rc_osc_en_out,
   output logic xtal_osc_en_out,
   output logic synth_en_out,
   output logic tx_en_out,
   output logic rx_en_out,
   output logic radio_general_pin_five_out,
   output logic [2:0] mcu_state_out,
   output logic cpu_clk_en_out,
   output logic main_osc_en_out,
   output logic ram_retain_out,
   output logic reg_retain_out,
   output logic pin_hold_out,
   output logic mcu_reset_out,
   output logic wake_irq_out,
   output logic [NUM_PERIPH-1:0] periph_clk_out
);
   pmm_pkg::radio_mode_t mode_ff; // Current radio mode
   pmm_pkg::radio_mode_t nxt_mode; // Next radio mode
   pmm_pkg::mcu_state_t mcu_ff; // Current MCU power state
   pmm_pkg::mcu_state_t nxt_mcu; // Next MCU power state
   logic [2:0] kb_sync_ff; // Keyboard wake synchroniser
   logic [2:0] uart_sync_ff; // UART line synchroniser
   logic [2:0] rtc_sync_ff; // RTC wake synchroniser
   logic kb_ff; // Filtered keyboard level
   logic uart_ff; // Filtered UART level
   logic rtc_ff; // Filtered RTC level
   logic wake; // Any wake event this cycle
   logic [15:0] rec_cnt_ff; // Reset-recovery countdown
   logic irq_ff; // Wake interrupt request, sticky
   logic [5:0] nxt_onehot; // Decoded mode bits
   logic main_reg_ff; // Registered main regulator enable
   logic rc_ff; // Registered RC oscillator enable
   logic xtal_ff; // Registered crystal enable
   logic synth_ff; // Registered synthesizer enable
   logic tx_ff; // Registered transmitter enable
   logic rx_ff; // Registered receiver enable
   logic [5:0] onehot_ff; // Registered one-hot mode
   logic [NUM_PERIPH-1:0] pclk_ff; // Registered peripheral clock enables

   // Radio mode register; illegal codes ignored so the mode never drifts
   always_comb begin
      nxt_mode = mode_ff;
      if (mode_wr_in && mode_in <= `RMODE_RX) begin // RULE7
         nxt_mode = pmm_pkg::radio_mode_t'(mode_in); // RULE6
      end
   end

   // Radio reset from the host GPIO overrides any command
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || radio_rst_in) begin // RULE16
         mode_ff <= pmm_pkg::RM_SLEEP;
      end else if (ce_in) begin
         mode_ff <= nxt_mode; // RULE6
      end
   end

   // Decode mode into one-hot; no two bits ever set together
   always_comb begin
      nxt_onehot = 6'h00;
      nxt_onehot[mode_ff] = 1'b1; // RULE17
   end

   // Resource enables per mode, registered so outputs are glitch free
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         main_reg_ff <= 1'b0;
         rc_ff <= 1'b0;
         xtal_ff <= 1'b0;
         synth_ff <= 1'b0;
         tx_ff <= 1'b0;
         rx_ff <= 1'b0;
         onehot_ff <= 6'h01;
      end else if (ce_in) begin
         onehot_ff <= nxt_onehot; // RULE17
         case (mode_ff)
            pmm_pkg::RM_SLEEP: begin // RULE1
               main_reg_ff <= 1'b0;
               rc_ff <= 1'b0;
               xtal_ff <= 1'b0;
               synth_ff <= 1'b0;
               tx_ff <= 1'b0;
               rx_ff <= 1'b0;
            end
            pmm_pkg::RM_IDLE: begin // RULE2
               main_reg_ff <= 1'b1;
               rc_ff <= 1'b1;
               xtal_ff <= 1'b0;
               synth_ff <= 1'b0;
               tx_ff <= 1'b0;
               rx_ff <= 1'b0;
            end
            pmm_pkg::RM_STANDBY: begin // RULE3
               main_reg_ff <= 1'b1;
               rc_ff <= 1'b0;
               xtal_ff <= 1'b1;
               synth_ff <= 1'b0;
               tx_ff <= 1'b0;
               rx_ff <= 1'b0;
            end
            pmm_pkg::RM_SYNTH: begin // RULE4
               main_reg_ff <= 1'b1;
               rc_ff <= 1'b0;
               xtal_ff <= 1'b1;
               synth_ff <= 1'b1;
               tx_ff <= 1'b0;
               rx_ff <= 1'b0;
            end
            // Active modes keep the synthesizer so the carrier stays locked
            pmm_pkg::RM_TX: begin // RULE5
               main_reg_ff <= 1'b1;
               rc_ff <= 1'b0;
               xtal_ff <= 1'b1;
               synth_ff <= 1'b1;
               tx_ff <= 1'b1;
               rx_ff <= 1'b0;
            end
            pmm_pkg::RM_RX: begin // RULE5
               main_reg_ff <= 1'b1;
               rc_ff <= 1'b0;
               xtal_ff <= 1'b1;
               synth_ff <= 1'b1;
               tx_ff <= 1'b0;
               rx_ff <= 1'b1;
            end
            default: begin
               main_reg_ff <= 1'b0;
               rc_ff <= 1'b0;
               xtal_ff <= 1'b0;
               synth_ff <= 1'b0;
               tx_ff <= 1'b0;
               rx_ff <= 1'b0;
            end
         endcase
      end
   end

   // Divided clock runs only while the crystal is up
   clk_divider #(
      .CNT_W(6)
   ) u_clkdiv (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in && ref_tick_in),
      .run_in(xtal_ff),
      .div_sel_in(clk_div_sel_in), // RULE15
      .clk_div_out(radio_general_pin_five_out)
   );

   // Three-stage synchronisers for wake pins
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         kb_sync_ff <= 3'h0;
         uart_sync_ff <= 3'h7;
         rtc_sync_ff <= 3'h0;
      end else if (ce_in) begin
         kb_sync_ff <= {kb_sync_ff[1:0], keyboard_wake_interrupt_in};
         uart_sync_ff <= {uart_sync_ff[1:0], uart_rx_in};
         rtc_sync_ff <= {rtc_sync_ff[1:0], rtc_wake_in};
      end
   end

   // Filtered level updates only once stages two and three agree
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         kb_ff <= 1'b0;
         uart_ff <= 1'b1;
         rtc_ff <= 1'b0;
      end else if (ce_in) begin
         if (kb_sync_ff[1] == kb_sync_ff[2]) begin
            kb_ff <= kb_sync_ff[2];
         end
         if (uart_sync_ff[1] == uart_sync_ff[2]) begin
            uart_ff <= uart_sync_ff[2];
         end
         if (rtc_sync_ff[1] == rtc_sync_ff[2]) begin
            rtc_ff <= rtc_sync_ff[2];
         end
      end
   end

   // Keyboard and RTC are level wakes; UART wakes on a low (start bit)
   assign wake = kb_ff | ~uart_ff | rtc_ff; // RULE13

   // MCU power state machine
   always_comb begin
      nxt_mcu = mcu_ff;
      case (mcu_ff)
         pmm_pkg::MS_RUN: begin
            if (deep_stop_req_in) begin
               nxt_mcu = pmm_pkg::MS_DEEP_STOP;
            end else if (ret_stop_req_in) begin
               nxt_mcu = pmm_pkg::MS_RET_STOP;
            end else if (wait_exec_in) begin
               nxt_mcu = pmm_pkg::MS_WAIT; // RULE12
            end
         end
         pmm_pkg::MS_WAIT: begin
            // Any interrupt ends wait, as well as the wake sources
            if (wake || irq_in) begin
               nxt_mcu = pmm_pkg::MS_RUN;
            end
         end
         pmm_pkg::MS_RET_STOP: begin
            if (wake) begin
               nxt_mcu = pmm_pkg::MS_RUN; // RULE11
            end
         end
         pmm_pkg::MS_DEEP_STOP: begin
            if (wake) begin
               nxt_mcu = pmm_pkg::MS_RECOVER; // RULE9
            end
         end
         pmm_pkg::MS_RECOVER: begin
            if (rec_cnt_ff == 16'h0001) begin
               nxt_mcu = pmm_pkg::MS_RUN;
            end
         end
         default: begin
            nxt_mcu = pmm_pkg::MS_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         mcu_ff <= pmm_pkg::MS_RUN;
      end else if (ce_in) begin
         mcu_ff <= nxt_mcu;
      end
   end

   // Recovery countdown loaded on wake from deepest stop
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rec_cnt_ff <= 16'h0000;
      end else if (ce_in) begin
         if (mcu_ff == pmm_pkg::MS_DEEP_STOP && wake) begin
            rec_cnt_ff <= 16'(RECOVERY_CYCLES); // RULE9
         end else if (rec_cnt_ff != 16'h0000) begin
            rec_cnt_ff <= rec_cnt_ff - 16'h0001;
         end
      end
   end

   // Wake interrupt: set on retentive wake, cleared once the interrupt is
   // taken back in run; set wins over clear
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         irq_ff <= 1'b0;
      end else if (ce_in) begin
         if (mcu_ff == pmm_pkg::MS_RET_STOP && wake) begin
            irq_ff <= 1'b1; // RULE11
         end else if (mcu_ff == pmm_pkg::MS_RUN && irq_in) begin
            irq_ff <= 1'b0;
         end
      end
   end

   // Peripheral clocks gated per module; all off in stop states
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pclk_ff <= '0;
      end else if (ce_in) begin
         if (mcu_ff == pmm_pkg::MS_RUN || mcu_ff == pmm_pkg::MS_WAIT) begin
            pclk_ff <= periph_clk_en_in; // RULE14
         end else begin
            pclk_ff <= '0;
         end
      end
   end

   // MCU power outputs decoded from state; retention differs by depth
   always_comb begin
      cpu_clk_en_out = (mcu_ff == pmm_pkg::MS_RUN); // RULE12
      main_osc_en_out = 1'b1;
      ram_retain_out = 1'b0;
      reg_retain_out = 1'b0;
      pin_hold_out = 1'b0;
      if (mcu_ff == pmm_pkg::MS_DEEP_STOP) begin // RULE8
         main_osc_en_out = 1'b0;
         ram_retain_out = 1'b1;
         pin_hold_out = 1'b1;
      end else if (mcu_ff == pmm_pkg::MS_RET_STOP) begin // RULE10
         main_osc_en_out = ret_stop_osc_en_in;
         ram_retain_out = 1'b1;
         reg_retain_out = 1'b1;
         pin_hold_out = 1'b1;
      end
   end

   assign mcu_reset_out = (mcu_ff == pmm_pkg::MS_RECOVER); // RULE9
   assign mcu_state_out = mcu_ff;
   assign wake_irq_out = irq_ff;
   assign periph_clk_out = pclk_ff;
   assign mode_out = mode_ff;
   assign mode_onehot_out = onehot_ff;
   assign main_reg_en_out = main_reg_ff;
   assign rc_osc_en_out = rc_ff;
   assign xtal_osc_en_out = xtal_ff;
   assign synth_en_out = synth_ff;
   assign tx_en_out = tx_ff;
   assign rx_en_out = rx_ff;
endmodule

// file: sim/pmm_monitor.sv
// Port checker for the power-mode manager: radio modes and MCU states
// Assumes a bind onto the top module; one clock, synchronous reset
`timescale 1ns/1ns
module pmm_monitor #(
   parameter int RECOVERY_CYCLES = 50
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic radio_rst_in,
   input wire logic mode_wr_in,
   input wire logic [2:0] mode_in,
   input wire logic ret_stop_osc_en_in,
   input wire logic [5:0] mode_onehot_out,
   input wire logic [2:0] mode_out,
   input wire logic main_reg_en_out,
   input wire logic rc_osc_en_out,
   input wire logic xtal_osc_en_out,
   input wire logic synth_en_out,
   input wire logic tx_en_out,
   input wire logic rx_en_out,
   input wire logic [2:0] mcu_state_out,
   input wire logic cpu_clk_en_out,
   input wire logic main_osc_en_out,
   input wire logic ram_retain_out,
   input wire logic reg_retain_out,
   input wire logic pin_hold_out,
   input wire logic wake_irq_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   // Enables per mode code, packed main, rc, xtal, synth, tx, rx
   localparam logic [5:0] EN_TAB [8] = '{6'h00, 6'h30, 6'h28, 6'h2C, 6'h2E, 6'h2D, 6'h00, 6'h00};
   // Enables as seen, same packing
   logic [5:0] en_v;
   // Recovery cycles; wide so a long hold cannot wrap
   logic [15:0] rec_cnt_ff;
   assign en_v = {main_reg_en_out, rc_osc_en_out, xtal_osc_en_out,
      synth_en_out, tx_en_out, rx_en_out};
   // Counts only while recovering, cleared in any other state
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || mcu_state_out != 3'h4) begin
         rec_cnt_ff <= 16'h0000;
      end else if (ce_in) begin
         rec_cnt_ff <= rec_cnt_ff + 16'h0001;
      end
   end
   // Accepted mode write
   sequence mode_cmd;
      ce_in && mode_wr_in && mode_in <= 3'h5 && !radio_rst_in;
   endsequence
   // Retentive stop left straight into run
   sequence ret_exit;
      mcu_state_out == 3'h2 ##1 mcu_state_out == 3'h0;
   endsequence
   // Last recovery cycle
   sequence rec_end;
      mcu_state_out == 3'h4 ##1 mcu_state_out != 3'h4;
   endsequence
   mode_take_a: assert property (mode_cmd |=> mode_out == $past(mode_in))
      else $error("mode write not taken");
   mode_hold_a: assert property (
      !radio_rst_in && !(ce_in && mode_wr_in && mode_in <= 3'h5) |=> $stable(mode_out))
      else $error("mode changed without command");
   radio_pwr_a: assert property (ce_in |=> en_v == EN_TAB[$past(mode_out)])
      else $error("radio enables wrong for mode");
   txrx_only_a: assert property (ce_in |=> tx_en_out == ($past(mode_out) == 3'h4)
      && rx_en_out == ($past(mode_out) == 3'h5))
      else $error("transmitter or receiver on in wrong mode");
   onehot_a: assert property (ce_in |=> mode_onehot_out == 6'h01 << $past(mode_out))
      else $error("one-hot mode does not match");
   deep_keep_a: assert property (mcu_state_out == 3'h3 |->
      ram_retain_out && pin_hold_out && !main_osc_en_out && !cpu_clk_en_out)
      else $error("deepest stop retention wrong");
   deep_wake_a: assert property (mcu_state_out == 3'h3 |=> mcu_state_out inside {3'h3, 3'h4})
      else $error("deepest stop left without recovery");
   recover_len_a: assert property (rec_end |->
      mcu_state_out == 3'h0 && rec_cnt_ff == RECOVERY_CYCLES)
      else $error("recovery length wrong");
   ret_keep_a: assert property (mcu_state_out == 3'h2 |-> ram_retain_out && reg_retain_out
      && pin_hold_out && main_osc_en_out == ret_stop_osc_en_in && !cpu_clk_en_out)
      else $error("retentive stop retention wrong");
   ret_wake_a: assert property (ret_exit |-> wake_irq_out)
      else $error("retentive wake without interrupt");
   wait_light_a: assert property (mcu_state_out == 3'h1 |->
      !cpu_clk_en_out && main_osc_en_out && !ram_retain_out && !pin_hold_out)
      else $error("wait state too deep");
endmodule

// file: sim/host_ctrl_model.sv
// Host model: writes radio mode codes and drives the radio reset line
// Assumes the bench calls its tasks from procedural code
`timescale 1ns/1ns
module host_ctrl_model (
   input wire logic mclk_in,
   output logic mode_wr_out,
   output logic [2:0] mode_out,
   output logic radio_rst_out
);
   // Quiet at start; code lines hold a non-mode pattern
   initial begin
      mode_wr_out = 1'b0;
      mode_out = 3'h7;
      radio_rst_out = 1'b0;
   end
   // One or two single-cycle writes, back to back when two is set
   task automatic send(input logic [2:0] a, input logic [2:0] b, input logic two);
      @(negedge mclk_in);
      mode_wr_out = 1'b1;
      mode_out = a;
      if (two) begin
         @(negedge mclk_in);
         mode_out = b;
         a = b;
      end
      @(negedge mclk_in);
      mode_wr_out = 1'b0;
      // Flipped after release so stale codes never pass for a command
      mode_out = ~a;
   endtask
   // Radio hardware reset held as a level from a general output
   task automatic rst_set(input logic v);
      @(negedge mclk_in);
      radio_rst_out = v;
   endtask
endmodule

// file: sim/sip_power_mode_manager_tb.sv
// Self-checking bench for the power-mode manager
// Assumes the checker and host model compile first; one 25 MHz clock
`timescale 1ns/1ns
module sip_power_mode_manager_tb;
   // Short recovery hold keeps the run brief
   localparam int REC = 3;
   logic mclk_in = 1'b0;
   logic sys_rst_in, ce_in, ref_tick_in, wait_exec_in, ret_stop_req_in, deep_stop_req_in;
   logic ret_stop_osc_en_in, keyboard_wake_interrupt_in, uart_rx_in, rtc_wake_in, irq_in;
   logic mode_wr_in, radio_rst_in, radio_general_pin_five_out, cpu_clk_en_out;
   logic main_reg_en_out, rc_osc_en_out, xtal_osc_en_out, synth_en_out, tx_en_out, rx_en_out;
   logic main_osc_en_out, ram_retain_out, reg_retain_out, pin_hold_out;
   logic mcu_reset_out, wake_irq_out;
   logic [2:0] mode_in, clk_div_sel_in, mode_out, mcu_state_out;
   logic [5:0] mode_onehot_out, en_w;
   logic [3:0] keep_w;
   logic [7:0] periph_clk_en_in, periph_clk_out;
   int fails = 0;
   int num_checks = 0;
   // Rows: code sent, expected mode, enables, one-hot; 6 and 7 are ignored
   logic [17:0] rows [8] = '{{3'h4, 3'h4, 6'h2E, 6'h10}, {3'h5, 3'h5, 6'h2D, 6'h20},
      {3'h6, 3'h5, 6'h2D, 6'h20}, {3'h3, 3'h3, 6'h2C, 6'h08}, {3'h2, 3'h2, 6'h28, 6'h04},
      {3'h7, 3'h2, 6'h28, 6'h04}, {3'h1, 3'h1, 6'h30, 6'h02}, {3'h0, 3'h0, 6'h00, 6'h01}};
   assign en_w = {main_reg_en_out, rc_osc_en_out, xtal_osc_en_out,
      synth_en_out, tx_en_out, rx_en_out};
   assign keep_w = {ram_retain_out, reg_retain_out, pin_hold_out, main_osc_en_out};
   // 40 ns clock
   always #20 mclk_in = ~mclk_in;
   host_ctrl_model host_u (.mclk_in, .mode_wr_out(mode_wr_in), .mode_out(mode_in),
      .radio_rst_out(radio_rst_in));
   sip_power_mode_manager #(.NUM_PERIPH(8), .RECOVERY_CYCLES(REC)) dut_u (.mclk_in,
      .sys_rst_in, .ce_in, .radio_rst_in, .mode_wr_in, .mode_in, .clk_div_sel_in,
      .ref_tick_in, .wait_exec_in, .ret_stop_req_in, .deep_stop_req_in, .ret_stop_osc_en_in,
      .keyboard_wake_interrupt_in, .uart_rx_in, .rtc_wake_in, .irq_in, .periph_clk_en_in,
      .mode_onehot_out, .mode_out, .main_reg_en_out, .rc_osc_en_out, .xtal_osc_en_out,
      .synth_en_out, .tx_en_out, .rx_en_out, .radio_general_pin_five_out, .mcu_state_out,
      .cpu_clk_en_out, .main_osc_en_out, .ram_retain_out, .reg_retain_out, .pin_hold_out,
      .mcu_reset_out, .wake_irq_out, .periph_clk_out);
   // Compare and count; unknowns never match
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Counts, verdict, end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Enter a stop, wake it from one source, then clear the wake flag
   task automatic stop_wake(input logic deep, input int src);
      int n;
      n = 0;
      {deep_stop_req_in, ret_stop_req_in} = {deep, !deep};
      @(negedge mclk_in);
      {deep_stop_req_in, ret_stop_req_in} = 2'h0;
      @(negedge mclk_in);
      chk("stop state", mcu_state_out, deep ? 3'h3 : 3'h2);
      chk("retention", keep_w, deep ? 4'hA : {3'h7, ret_stop_osc_en_in});
      chk("mode kept", mode_out, 3'h2);
      {keyboard_wake_interrupt_in, uart_rx_in, rtc_wake_in} = {src == 0, src != 1, src == 2};
      // Bounded: sync chain plus filter is a handful of cycles
      while (mcu_state_out === (deep ? 3'h3 : 3'h2) && n < 20) begin
         @(negedge mclk_in);
         n++;
      end
      {keyboard_wake_interrupt_in, uart_rx_in, rtc_wake_in} = 3'h2;
      chk("woken", mcu_state_out, deep ? 3'h4 : 3'h0);
      chk("wake flag", deep ? mcu_reset_out : wake_irq_out, 1'b1);
      n = 0;
      while (mcu_state_out === 3'h4 && n < 100) begin
         @(negedge mclk_in);
         n++;
      end
      chk("recovery", n, deep ? REC : 0);
      repeat (6) @(negedge mclk_in);
      irq_in = 1'b1;
      @(negedge mclk_in);
      irq_in = 1'b0;
      @(negedge mclk_in);
      chk("irq clear", wake_irq_out, 1'b0);
   endtask
   initial begin
      int n;
      logic prev;
      {sys_rst_in, ce_in, ref_tick_in, uart_rx_in} = 4'hF;
      {wait_exec_in, ret_stop_req_in, deep_stop_req_in, ret_stop_osc_en_in} = 4'h0;
      {keyboard_wake_interrupt_in, rtc_wake_in, irq_in, clk_div_sel_in} = 6'h00;
      periph_clk_en_in = 8'h00;
      repeat (2) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      // Table of writes, each checked after the two-cycle latency
      foreach (rows[i]) begin
         host_u.send(rows[i][17:15], 3'h0, 1'b0);
         repeat (2) @(negedge mclk_in);
         chk("mode", mode_out, rows[i][14:12]);
         chk("enables", en_w, rows[i][11:6]);
         chk("onehot", mode_onehot_out, rows[i][5:0]);
      end
      host_u.send(3'h4, 3'h5, 1'b1);
      repeat (2) @(negedge mclk_in);
      chk("back to back", en_w, 6'h2D);
      ce_in = 1'b0;
      host_u.send(3'h3, 3'h0, 1'b0);
      ce_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      chk("frozen write", mode_out, 3'h5);
      host_u.rst_set(1'b1);
      host_u.send(3'h1, 3'h0, 1'b0);
      repeat (2) @(negedge mclk_in);
      chk("radio reset", {mode_out, en_w}, 9'h000);
      host_u.rst_set(1'b0);
      // Divided clock in standby; each tick stands for one reference edge
      host_u.send(3'h2, 3'h0, 1'b0);
      for (int c = 0; c < 8; c++) begin
         clk_div_sel_in = 3'(c);
         repeat (40) @(negedge mclk_in);
         n = 0;
         prev = radio_general_pin_five_out;
         repeat (64) begin
            @(negedge mclk_in);
            n += int'(radio_general_pin_five_out && !prev);
            prev = radio_general_pin_five_out;
         end
         chk("divided clock", n, 64 >> (c > 5 ? 6 : c + 1));
      end
      // No ticks: output must hold; an odd wait catches a free toggle
      ref_tick_in = 1'b0;
      clk_div_sel_in = 3'h0;
      prev = radio_general_pin_five_out;
      repeat (7) @(negedge mclk_in);
      chk("tick hold", radio_general_pin_five_out, prev);
      ref_tick_in = 1'b1;
      periph_clk_en_in = 8'hA5;
      repeat (2) @(negedge mclk_in);
      chk("periph gating", periph_clk_out, 8'hA5);
      ret_stop_osc_en_in = 1'b1;
      stop_wake(1'b0, 2);
      ret_stop_osc_en_in = 1'b0;
      stop_wake(1'b0, 1);
      stop_wake(1'b1, 0);
      // Wait state; a stop request there is refused
      wait_exec_in = 1'b1;
      @(negedge mclk_in);
      {wait_exec_in, deep_stop_req_in} = 2'h1;
      @(negedge mclk_in);
      deep_stop_req_in = 1'b0;
      chk("wait", {mcu_state_out, cpu_clk_en_out, main_osc_en_out, ram_retain_out}, 6'h0A);
      irq_in = 1'b1;
      @(negedge mclk_in);
      irq_in = 1'b0;
      chk("wait end", mcu_state_out, 3'h0);
      host_u.send(3'h0, 3'h0, 1'b0);
      repeat (4) @(negedge mclk_in);
      chk("clock idle", radio_general_pin_five_out, 1'b0);
      // Second reset in mid-run from transmit
      host_u.send(3'h4, 3'h0, 1'b0);
      repeat (2) @(negedge mclk_in);
      sys_rst_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      chk("reset radio", {mode_out, en_w, mode_onehot_out}, 15'h0001);
      chk("reset mcu", {mcu_state_out, cpu_clk_en_out, main_osc_en_out, keep_w[3:1],
         mcu_reset_out, wake_irq_out}, 10'h060);
      chk("reset periph", periph_clk_out, 8'h00);
      print_verdict();
   end
   // Watchdog: the tests need about 950 cycles
   initial begin
      repeat (5000) @(posedge mclk_in);
      fails++;
      print_verdict();
   end
endmodule
bind sip_power_mode_manager pmm_monitor #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) mon_u (
   .mclk_in, .sys_rst_in, .ce_in, .radio_rst_in, .mode_wr_in, .mode_in, .ret_stop_osc_en_in,
   .mode_onehot_out, .mode_out, .main_reg_en_out, .rc_osc_en_out, .xtal_osc_en_out,
   .synth_en_out, .tx_en_out, .rx_en_out, .mcu_state_out, .cpu_clk_en_out, .main_osc_en_out,
   .ram_retain_out, .reg_retain_out, .pin_hold_out, .wake_irq_out);
